// file: hdl/disk_read_pkg.sv
// Shared constants and types for the disk read command executor
package disk_read_pkg;
  // Task file addresses
  localparam logic [9:0] OFF_DATA     = 10'h1F0;
  localparam logic [9:0] OFF_FEATURE  = 10'h1F1;
  localparam logic [9:0] OFF_TALLY    = 10'h1F2;
  localparam logic [9:0] OFF_SECTOR   = 10'h1F3;
  localparam logic [9:0] OFF_TRACK_LO = 10'h1F4;
  localparam logic [9:0] OFF_TRACK_HI = 10'h1F5;
  localparam logic [9:0] OFF_DRVHEAD  = 10'h1F6;
  localparam logic [9:0] OFF_COMMAND  = 10'h1F7;
  // Command codes
  localparam logic [7:0] CMD_READ      = 8'h20;
  localparam logic [7:0] CMD_READ_NR   = 8'h21;
  localparam logic [7:0] CMD_READ_MULT = 8'hC4;
  localparam logic [7:0] CMD_DMA       = 8'hC8;
  localparam logic [7:0] CMD_DMA_NR    = 8'hC9;
  localparam logic [7:0] CMD_VERIFY    = 8'h40;
  localparam logic [7:0] CMD_VERIFY_NR = 8'h41;
  localparam logic [7:0] CMD_SET_MULT  = 8'hC6;
  localparam logic [7:0] CMD_SET_FEAT  = 8'hEF;
  // Transfer mode feature and mode ranges
  localparam logic [7:0] FEAT_XFER_MODE = 8'h03;
  localparam logic [4:0] MODE_MDMA      = 5'h04;
  localparam logic [2:0] MDMA_MAX       = 3'h2;
  localparam logic [4:0] MODE_UDMA      = 5'h08;
  localparam logic [2:0] UDMA_MAX       = 3'h5;
  // Status and error bit positions
  localparam int ST_BSY  = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_DSC  = 4;
  localparam int ST_DRQ  = 3;
  localparam int ST_ERR  = 0;
  localparam int ER_UNC  = 6;
  localparam int ER_ABRT = 2;
  // Reset values
  localparam logic [7:0] TASK_RESET  = 8'h00;
  localparam logic [7:0] SECT_RESET  = 8'h01;
  localparam logic [7:0] MODE_RESET  = 8'h00;
  // Zero count means the full range
  localparam logic [8:0] FULL_COUNT  = 9'h100;
  // Read command family
  typedef enum logic [1:0] {
    K_PIO  = 2'b00,
    K_MULT = 2'b01,
    K_DMA  = 2'b10,
    K_VFY  = 2'b11
  } kind_t;
  // Executor states
  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_FETCH = 2'b01,
    S_XFER  = 2'b10
  } state_t;
  // Sector fetch states
  typedef enum logic [1:0] {
    F_IDLE = 2'b00,
    F_SEEK = 2'b01,
    F_READ = 2'b10
  } fstate_t;
endpackage : disk_read_pkg

// file: hdl/fetch_if.sv
// Request and result path between executor and sector fetch unit
`timescale 1ns/1ps
interface fetch_if;
  logic        start;     // One-cycle request for a sector
  logic [19:0] trackKey;  // Track that holds the sector
  logic [7:0]  sectorKey; // Sector within the track
  logic        done;      // One-cycle completion
  logic        bad;       // Unrecoverable with done
  modport exec (output start, trackKey, sectorKey, input done, bad);
  modport unit (input start, trackKey, sectorKey, output done, bad);
endinterface : fetch_if

// file: hdl/sector_fetch.sv
// Seeks when needed, reads one sector, retries on media error
`timescale 1ns/1ps
module sector_fetch
  import disk_read_pkg::*;
#(
  parameter logic [3:0] RETRY_LIMIT = 4'h3
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Executor side
  fetch_if.unit            fi,
  // Media side
  output logic             seekGo,
  output logic [19:0]      mediaTrack,
  input  wire logic        seekDone,
  output logic             readGo,
  output logic [7:0]       mediaSector,
  input  wire logic        readDone,
  input  wire logic        readBad
);
  fstate_t     fst_q,   fst_d;    // Fetch state
  logic [19:0] trk_q,   trk_d;    // Track under the heads
  logic        trkOk_q, trkOk_d;  // Head position known
  logic [7:0]  sec_q,   sec_d;    // Target sector
  logic [3:0]  tries_q, tries_d;  // Retries used
  logic        seek_q,  seek_d;
  logic        read_q,  read_d;
  logic        done_q,  done_d;
  logic        bad_q,   bad_d;

  // Next state of the fetch sequence
  always_comb begin
    fst_d   = fst_q;
    trk_d   = trk_q;
    trkOk_d = trkOk_q;
    sec_d   = sec_q;
    tries_d = tries_q;
    seek_d  = 1'b0;
    read_d  = 1'b0;
    done_d  = 1'b0;
    bad_d   = bad_q;
    unique case (fst_q)
      F_IDLE: begin
        if (fi.start) begin
          sec_d   = fi.sectorKey;
          tries_d = 4'h0;
          bad_d   = 1'b0;
          trk_d   = fi.trackKey;
          if (!trkOk_q || fi.trackKey != trk_q) begin
            // Implied seek before touching the sector
            seek_d = 1'b1;
            fst_d  = F_SEEK;
          end else begin
            read_d = 1'b1;
            fst_d  = F_READ;
          end
        end
      end
      F_SEEK: begin
        if (seekDone) begin
          trkOk_d = 1'b1;
          read_d  = 1'b1;
          fst_d   = F_READ;
        end
      end
      F_READ: begin
        if (readDone) begin
          if (readBad && tries_q < RETRY_LIMIT) begin
            // Retry regardless of the command's retry bit
            tries_d = tries_q + 4'h1;
            read_d  = 1'b1;
          end else begin
            done_d = 1'b1;
            bad_d  = readBad;
            fst_d  = F_IDLE;
          end
        end
      end
      // Unused code falls back to idle
      default: fst_d = F_IDLE;
    endcase
  end

  // Fetch registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fst_q   <= F_IDLE;
      trk_q   <= 20'h00000;
      trkOk_q <= 1'b0;
      sec_q   <= 8'h00;
      tries_q <= 4'h0;
      seek_q  <= 1'b0;
      read_q  <= 1'b0;
      done_q  <= 1'b0;
      bad_q   <= 1'b0;
    end else begin
      fst_q   <= fst_d;
      trk_q   <= trk_d;
      trkOk_q <= trkOk_d;
      sec_q   <= sec_d;
      tries_q <= tries_d;
      seek_q  <= seek_d;
      read_q  <= read_d;
      done_q  <= done_d;
      bad_q   <= bad_d;
    end
  end

  assign seekGo      = seek_q;
  assign readGo      = read_q;
  assign mediaTrack  = trk_q;
  assign mediaSector = sec_q;
  assign fi.done     = done_q;
  assign fi.bad      = bad_q;

  // Checks on seek and retry
  property p_seek_first;
    @(posedge clk) disable iff (reset)
    (fst_q == F_IDLE && fi.start && (!trkOk_q || fi.trackKey != trk_q))
      |=> seek_q && !read_q;
  endproperty
  a_seek_first: assert property (p_seek_first)
    else $error("track change did not seek first");
  property p_retry;
    @(posedge clk) disable iff (reset)
    (fst_q == F_READ && readDone && readBad && tries_q < RETRY_LIMIT)
      |=> read_q && !done_q;
  endproperty
  a_retry: assert property (p_retry)
    else $error("media error was not retried");
  property p_cov_retry;
    @(posedge clk) disable iff (reset) read_q && tries_q != 4'h0;
  endproperty
  c_retry: cover property (p_cov_retry);
endmodule : sector_fetch

// file: hdl/disk_read_command_executor.sv
// Read command family executor behind the parallel task file
// Functional notes
// - 20h and 21h run sector read
// - block address is head, track, sector
// - Zero tally means 256 sectors
// - Seek to track before reading
// - Always retry failing sector
// - Data request precedes data, even erroneous
// - Success: last address kept, tally zero
// - Read error: stop, failing address, remainder
// - C4h runs multiple sector read
// - Multiple read flags only at blocks
// - Full blocks, then remainder block
// - Multiple without block size aborts
// - C8h/C9h DMA, device drives DMARQ
// - DMA status posted once at end
// - DMA error stops, interrupts, reports
// - Feature command picks DMA mode
// - 40h/41h verify, no data sent
// - Verify done: idle, interrupt, last address
// - Verify error: stop, address, remainder
// - Command write starts execution
`timescale 1ns/1ps
module disk_read_command_executor
  import disk_read_pkg::*;
#(
  parameter int         SECTOR_WORDS      = 256,
  parameter logic [7:0] SECTORS_PER_TRACK = 8'h3F,
  parameter logic [4:0] HEAD_COUNT        = 5'h10,
  parameter logic [7:0] MAX_BLOCK         = 8'h10,
  parameter logic [3:0] RETRY_LIMIT       = 4'h3
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Task file access
  input  wire logic [9:0]  hostAddr,
  input  wire logic        hostWr,
  input  wire logic [7:0]  hostWrData,
  input  wire logic        hostRd,
  output logic [15:0]      hostRdData,
  // Host signalling
  output logic             intrq,
  output logic             dmarq,
  input  wire logic        dmaStrobe,
  output logic [7:0]       xferMode,
  // Sector data from the media
  input  wire logic [15:0] mediaWord,
  output logic             wordPull,
  // Media control
  output logic             seekGo,
  output logic [19:0]      mediaTrack,
  input  wire logic        seekDone,
  output logic             readGo,
  output logic [7:0]       mediaSector,
  input  wire logic        readDone,
  input  wire logic        readBad
);
  localparam int WW = $clog2(SECTOR_WORDS + 1);
  localparam logic [WW-1:0] LAST_WORD = WW'(SECTOR_WORDS - 1);

  // Parameter sanity
  if (SECTOR_WORDS < 1 || SECTORS_PER_TRACK == 8'h00 ||
      HEAD_COUNT == 5'h00 || HEAD_COUNT > 5'h10 || MAX_BLOCK == 8'h00)
    $error("disk_read_command_executor: unsupported parameters");

  fetch_if fi ();

  // Next address after a sector, CHS or block form
  function automatic logic [31:0] nextAddr(input logic [31:0] a);
    logic [31:0] r;
    r = a;
    if (a[30]) begin
      r[27:0] = a[27:0] + 28'h1;
    end else if (a[7:0] < SECTORS_PER_TRACK) begin
      r[7:0] = a[7:0] + 8'h01;
    end else begin
      r[7:0] = 8'h01;
      if ({1'b0, a[27:24]} + 5'h01 < HEAD_COUNT) begin
        r[27:24] = a[27:24] + 4'h1;
      end else begin
        r[27:24] = 4'h0;
        r[23:8]  = a[23:8] + 16'h0001;
      end
    end
    return r;
  endfunction : nextAddr

  state_t      st_q,    st_d;     // Executor state
  kind_t       kind_q,  kind_d;   // Running command family
  logic [7:0]  feat_q,  feat_d;   // Feature parameter
  logic [7:0]  err_q,   err_d;    // Error information
  logic [7:0]  tally_q, tally_d;  // Sector tally
  logic [31:0] addr_q,  addr_d;   // Drive/head, tracks, sector
  logic [8:0]  rem_q,   rem_d;    // Sectors still to do
  logic [8:0]  blk_q,   blk_d;    // Sectors left in this block
  logic [7:0]  bsize_q, bsize_d;  // Block size from setup
  logic        mult_q,  mult_d;   // Multiple mode enabled
  logic [WW-1:0] wcnt_q, wcnt_d;  // Words sent of this sector
  logic        fail_q,  fail_d;   // Sector in transfer failed
  logic        bsy_q,   bsy_d;
  logic        drq_q,   drq_d;
  logic        errb_q,  errb_d;
  logic        irq_q,   irq_d;
  logic        dmarq_q, dmarq_d;
  logic [7:0]  mode_q,  mode_d;
  logic        pull_q,  pull_d;
  logic [15:0] rdat_q,  rdat_d;
  logic        cmdWr, take, lastWord;
  logic [7:0]  status;
  logic [8:0]  fullCnt;

  // Status byte as the host sees it
  assign status = {bsy_q, 1'b1, 1'b0, 1'b1, drq_q, 2'b00, errb_q};
  // Task file writes only count while idle
  assign cmdWr = hostWr && !bsy_q && !drq_q && hostAddr == OFF_COMMAND;
  assign fullCnt = (tally_q == 8'h00) ? FULL_COUNT : {1'b0, tally_q};
  // One data word moves, by PIO read or DMA strobe
  assign take = (st_q == S_XFER) &&
                (kind_q == K_DMA ? dmaStrobe
                                 : hostRd && hostAddr == OFF_DATA);
  assign lastWord = take && wcnt_q == LAST_WORD;
  // Keys follow the next address so a chained fetch gets the new sector
  assign fi.trackKey  = addr_d[30] ? addr_d[27:8]
                                   : {addr_d[23:8], addr_d[27:24]};
  assign fi.sectorKey = addr_d[7:0];

  // Command decode, sequencing and task file
  always_comb begin
    st_d = st_q; kind_d = kind_q; feat_d = feat_q; err_d = err_q;
    tally_d = tally_q; addr_d = addr_q; rem_d = rem_q; blk_d = blk_q;
    bsize_d = bsize_q; mult_d = mult_q; wcnt_d = wcnt_q;
    fail_d = fail_q; bsy_d = bsy_q; drq_d = drq_q; errb_d = errb_q;
    dmarq_d = dmarq_q; mode_d = mode_q; rdat_d = rdat_q;
    irq_d = irq_q; pull_d = 1'b0; fi.start = 1'b0;
    // Status read acknowledges the interrupt
    if (hostRd && hostAddr == OFF_COMMAND) irq_d = 1'b0;
    // Register reads
    if (hostRd) begin
      unique case (hostAddr)
        OFF_FEATURE:  rdat_d = {8'h00, err_q};
        OFF_TALLY:    rdat_d = {8'h00, tally_q};
        OFF_SECTOR:   rdat_d = {8'h00, addr_q[7:0]};
        OFF_TRACK_LO: rdat_d = {8'h00, addr_q[15:8]};
        OFF_TRACK_HI: rdat_d = {8'h00, addr_q[23:16]};
        OFF_DRVHEAD:  rdat_d = {8'h00, addr_q[31:24]};
        OFF_COMMAND:  rdat_d = {8'h00, status};
        default:      rdat_d = 16'h0000;
      endcase
    end
    // Parameter writes while idle
    if (hostWr && !bsy_q && !drq_q) begin
      unique case (hostAddr)
        OFF_FEATURE:  feat_d = hostWrData;
        OFF_TALLY:    tally_d = hostWrData;
        OFF_SECTOR:   addr_d[7:0] = hostWrData;
        OFF_TRACK_LO: addr_d[15:8] = hostWrData;
        OFF_TRACK_HI: addr_d[23:16] = hostWrData;
        OFF_DRVHEAD:  addr_d[31:24] = hostWrData;
        default: ;
      endcase
    end
    unique case (st_q)
      S_IDLE: begin
        if (cmdWr) begin
          // Execution starts on the command write
          err_d = 8'h00; errb_d = 1'b0; fail_d = 1'b0;
          rem_d = fullCnt; blk_d = 9'h000;
          unique case (hostWrData)
            CMD_READ, CMD_READ_NR,
            CMD_VERIFY, CMD_VERIFY_NR,
            CMD_DMA, CMD_DMA_NR: begin
              kind_d = hostWrData[7] ? K_DMA
                     : (hostWrData[6] ? K_VFY : K_PIO);
              bsy_d = 1'b1; fi.start = 1'b1; st_d = S_FETCH;
            end
            CMD_READ_MULT: begin
              kind_d = K_MULT;
              if (mult_q) begin
                bsy_d = 1'b1; fi.start = 1'b1; st_d = S_FETCH;
              end else begin
                err_d[ER_ABRT] = 1'b1; errb_d = 1'b1;
                irq_d = 1'b1;
              end
            end
            CMD_SET_MULT: begin
              irq_d = 1'b1;
              if (tally_q == 8'h00) begin
                mult_d = 1'b0;
              end else if (tally_q <= MAX_BLOCK &&
                           (tally_q & (tally_q - 8'h01)) == 8'h00) begin
                bsize_d = tally_q; mult_d = 1'b1;
              end else begin
                err_d[ER_ABRT] = 1'b1; errb_d = 1'b1;
              end
            end
            CMD_SET_FEAT: begin
              irq_d = 1'b1;
              if (feat_q == FEAT_XFER_MODE &&
                  ((tally_q[7:3] == MODE_MDMA && tally_q[2:0] <= MDMA_MAX) ||
                   (tally_q[7:3] == MODE_UDMA && tally_q[2:0] <= UDMA_MAX)))
                mode_d = tally_q;
              else begin
                err_d[ER_ABRT] = 1'b1; errb_d = 1'b1;
              end
            end
            default: begin
              err_d[ER_ABRT] = 1'b1; errb_d = 1'b1; irq_d = 1'b1;
            end
          endcase
        end
      end
      S_FETCH: begin
        if (fi.done) begin
          if (fi.bad && (kind_q == K_VFY || kind_q == K_DMA)) begin
            // Stop at the failing sector, remainder left in tally
            err_d[ER_UNC] = 1'b1; errb_d = 1'b1;
            tally_d = rem_q[7:0]; bsy_d = 1'b0;
            irq_d = 1'b1; st_d = S_IDLE;
          end else if (kind_q == K_VFY) begin
            if (rem_q == 9'h001) begin
              // Verified all; address stays on the last sector
              tally_d = 8'h00; bsy_d = 1'b0;
              irq_d = 1'b1; st_d = S_IDLE;
            end else begin
              rem_d = rem_q - 9'h001; tally_d = rem_d[7:0];
              addr_d = nextAddr(addr_q); fi.start = 1'b1;
            end
          end else begin
            st_d = S_XFER; wcnt_d = '0; fail_d = fi.bad;
            if (fi.bad) begin
              err_d[ER_UNC] = 1'b1; errb_d = 1'b1;
            end
            if (kind_q == K_DMA) begin
              dmarq_d = 1'b1;
            end else if (kind_q == K_PIO) begin
              drq_d = 1'b1; bsy_d = 1'b0;
              irq_d = 1'b1;
            end else if (blk_q == 9'h000) begin
              // Block start: full block or remainder block
              blk_d = (rem_q < {1'b0, bsize_q}) ? rem_q
                                                : {1'b0, bsize_q};
              drq_d = 1'b1; bsy_d = 1'b0; irq_d = 1'b1;
            end
          end
        end
      end
      S_XFER: begin
        if (take) begin
          rdat_d = mediaWord; pull_d = 1'b1;
          wcnt_d = wcnt_q + WW'(1);
        end
        if (lastWord) begin
          dmarq_d = 1'b0; blk_d = blk_q - 9'h001;
          if (fail_q) begin
            tally_d = rem_q[7:0]; drq_d = 1'b0;
            bsy_d = 1'b0; st_d = S_IDLE;
          end else if (rem_q == 9'h001) begin
            tally_d = 8'h00; drq_d = 1'b0;
            bsy_d = 1'b0; st_d = S_IDLE;
            if (kind_q == K_DMA) irq_d = 1'b1;
          end else begin
            rem_d = rem_q - 9'h001; tally_d = rem_d[7:0];
            addr_d = nextAddr(addr_q); fi.start = 1'b1;
            st_d = S_FETCH;
            if (kind_q != K_DMA && !(kind_q == K_MULT && blk_q != 9'h001))
            begin
              drq_d = 1'b0; bsy_d = 1'b1;
            end
          end
        end
      end
      default: st_d = S_IDLE;
    endcase
  end

  // Executor registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= S_IDLE; kind_q <= K_PIO; feat_q <= TASK_RESET;
      err_q <= TASK_RESET; tally_q <= SECT_RESET;
      addr_q <= {TASK_RESET, TASK_RESET, TASK_RESET, SECT_RESET};
      rem_q <= 9'h000; blk_q <= 9'h000; bsize_q <= TASK_RESET;
      mult_q <= 1'b0; wcnt_q <= '0; fail_q <= 1'b0; bsy_q <= 1'b0;
      drq_q <= 1'b0; errb_q <= 1'b0; irq_q <= 1'b0; dmarq_q <= 1'b0;
      mode_q <= MODE_RESET; pull_q <= 1'b0; rdat_q <= 16'h0000;
    end else begin
      st_q <= st_d; kind_q <= kind_d; feat_q <= feat_d;
      err_q <= err_d; tally_q <= tally_d; addr_q <= addr_d;
      rem_q <= rem_d; blk_q <= blk_d; bsize_q <= bsize_d;
      mult_q <= mult_d; wcnt_q <= wcnt_d; fail_q <= fail_d;
      bsy_q <= bsy_d; drq_q <= drq_d; errb_q <= errb_d;
      irq_q <= irq_d; dmarq_q <= dmarq_d; mode_q <= mode_d;
      pull_q <= pull_d; rdat_q <= rdat_d;
    end
  end

  assign hostRdData = rdat_q;
  assign intrq      = irq_q;
  assign dmarq      = dmarq_q;
  assign xferMode   = mode_q;
  assign wordPull   = pull_q;

  // Seek, retry and media handshakes
  sector_fetch #(.RETRY_LIMIT(RETRY_LIMIT)) u_fetch (
    .clk        (clk),
    .reset      (reset),
    .fi         (fi.unit),
    .seekGo     (seekGo),
    .mediaTrack (mediaTrack),
    .seekDone   (seekDone),
    .readGo     (readGo),
    .mediaSector(mediaSector),
    .readDone   (readDone),
    .readBad    (readBad)
  );

  // Protocol checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_read_start;
    cmdWr && hostWrData[7:1] == CMD_READ[7:1] |=> bsy_q && st_q == S_FETCH;
  endproperty
  a_read_start: assert property (p_read_start)
    else $error("read command did not start");
  property p_zero_tally;
    cmdWr && tally_q == 8'h00 |=> rem_q == FULL_COUNT;
  endproperty
  a_zero_tally: assert property (p_zero_tally)
    else $error("zero tally not taken as 256");
  property p_mult_abort;
    cmdWr && hostWrData == CMD_READ_MULT && !mult_q
      |=> err_q[ER_ABRT] && errb_q && irq_q && !bsy_q;
  endproperty
  a_mult_abort: assert property (p_mult_abort)
    else $error("multiple read without setup not aborted");
  property p_dmarq_own;
    dmarq_q |-> kind_q == K_DMA && st_q == S_XFER;
  endproperty
  a_dmarq_own: assert property (p_dmarq_own)
    else $error("DMARQ outside a DMA transfer");
  property p_drq_irq;
    $rose(drq_q) |-> irq_q && !bsy_q;
  endproperty
  a_drq_irq: assert property (p_drq_irq)
    else $error("data request without interrupt");
  property p_dma_once;
    $rose(irq_q) && kind_q == K_DMA |-> !bsy_q && !dmarq_q;
  endproperty
  a_dma_once: assert property (p_dma_once)
    else $error("DMA interrupt before completion");
  property p_verify_nodata;
    kind_q == K_VFY |-> !drq_q && !dmarq_q;
  endproperty
  a_verify_nodata: assert property (p_verify_nodata)
    else $error("verify moved data");
  property p_verify_end;
    st_q == S_FETCH && fi.done && !fi.bad && kind_q == K_VFY &&
      rem_q == 9'h001 |=> tally_q == 8'h00 && !bsy_q && irq_q &&
      addr_q == $past(addr_q);
  endproperty
  a_verify_end: assert property (p_verify_end)
    else $error("verify completion wrong");
  property p_verify_err;
    st_q == S_FETCH && fi.done && fi.bad && kind_q == K_VFY
      |=> tally_q == $past(rem_q[7:0]) && err_q[ER_UNC] && !bsy_q;
  endproperty
  a_verify_err: assert property (p_verify_err)
    else $error("verify error report wrong");
  property p_cov_mult;
    st_q == S_XFER && kind_q == K_MULT && lastWord && blk_q == 9'h001;
  endproperty
  c_mult: cover property (p_cov_mult);
  property p_cov_dma_end;
    kind_q == K_DMA && $rose(irq_q);
  endproperty
  c_dma_end: cover property (p_cov_dma_end);
  property p_cov_err;
    fail_q && lastWord;
  endproperty
  c_err: cover property (p_cov_err);
endmodule : disk_read_command_executor

// file: tb/media_model.sv
// Behavioural media: answers seeks and reads, one sector can fail
`timescale 1ns/1ps
module media_model (
  // Clock
  input  wire logic        clk,
  // Requests from the device
  input  wire logic        seekGo,
  input  wire logic        readGo,
  input  wire logic [7:0]  mediaSector,
  input  wire logic [7:0]  badSector,
  // Answers
  output logic             seekDone,
  output logic             readDone,
  output logic             readBad,
  output logic [15:0]      mediaWord,
  output int               tries
);
  // Idle answers at time zero
  initial begin
    {seekDone, readDone, readBad, tries} = '0;
  end
  // Answer one cycle after each pulse; the bad sector always fails
  always @(posedge clk) begin
    seekDone <= seekGo;
    readDone <= readGo;
    readBad  <= readGo && mediaSector == badSector;
    if (readGo && mediaSector == badSector) tries <= tries + 1;
  end
  // Each word carries the sector it came from
  assign mediaWord = {8'hD0, mediaSector};
endmodule : media_model

// file: tb/disk_read_command_executor_tb.sv
// Self-checking bench for the disk read command executor
`timescale 1ns/1ps
module disk_read_command_executor_tb;
  import disk_read_pkg::*;
  logic        clk, reset, hostWr, hostRd, seekGo, seekDone, readGo;
  logic        readDone, readBad, intrq, dmaStrobe, dmarq;
  logic [9:0]  hostAddr;
  logic [7:0]  hostWrData, mediaSector, badSector, xferMode;
  logic [15:0] hostRdData, mediaWord;
  logic [19:0] mediaTrack;
  int          fails, comparisons, cycles, tries, t0;
  // Device under test with short sectors
  disk_read_command_executor #(.SECTOR_WORDS(4)) disk_read_command_executor_i (
    .clk, .reset, .hostAddr, .hostWr, .hostWrData, .hostRd, .hostRdData,
    .intrq, .dmarq, .dmaStrobe, .xferMode, .mediaWord,
    .wordPull(), .seekGo, .mediaTrack, .seekDone, .readGo, .mediaSector,
    .readDone, .readBad);
  // Far side media
  media_model media_model_i (.clk, .seekGo, .readGo, .mediaSector,
    .badSector, .seekDone, .readDone, .readBad, .mediaWord, .tries);
  // Clock and hang guard
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, s);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One register write pulse
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk) {hostAddr, hostWrData, hostWr} <= {a, d, 1'b1};
    @(posedge clk) hostWr <= 1'b0;
  endtask : wr
  // One read pulse, data is checked the cycle after
  task automatic rd(input logic [9:0] a, input logic [15:0] e, input string n);
    @(posedge clk) {hostAddr, hostRd} <= {a, 1'b1};
    @(posedge clk) hostRd <= 1'b0;
    #1 chk(n, e, hostRdData);
  endtask : rd
  // Block address mode, start sector, count, then command
  task automatic issue(input logic [7:0] sec, cnt, cmd);
    wr(OFF_DRVHEAD, 8'h40);
    wr(OFF_TRACK_HI, 8'h00);
    wr(OFF_TRACK_LO, 8'h00);
    wr(OFF_SECTOR, sec);
    wr(OFF_TALLY, cnt);
    wr(OFF_COMMAND, cmd);
  endtask : issue
  // Four data words of one sector
  task automatic words(input logic [7:0] s);
    for (int w = 0; w < 4; w++) rd(OFF_DATA, {8'hD0, s}, "word");
  endtask : words
  // Bounded wait for an interrupt
  task automatic wait_irq();
    for (int i = 0; i < 200 && intrq !== 1'b1; i++) @(posedge clk);
    chk("intrq", 16'h0001, {15'h0000, intrq});
  endtask : wait_irq
  task automatic t_reset();
    rd(OFF_COMMAND, 16'h0050, "status");
    rd(OFF_TALLY, 16'h0001, "tally");
    rd(OFF_SECTOR, 16'h0001, "sector");
    $display("reset values done");
  endtask : t_reset
  // Two sectors read word by word, one interrupt per sector
  task automatic t_pio(input logic [7:0] cmd);
    issue(8'h05, 8'h02, cmd);
    for (int s = 0; s < 2; s++) begin
      wait_irq();
      rd(OFF_COMMAND, 16'h0058, "drq status");
      words(8'(5 + s));
    end
    repeat (3) @(posedge clk);
    chk("final intrq", 16'h0000, {15'h0000, intrq});
    rd(OFF_COMMAND, 16'h0050, "end status");
    rd(OFF_TALLY, 16'h0000, "end tally");
    rd(OFF_SECTOR, 16'h0006, "end sector");
    $display("sector read %h done", cmd);
  endtask : t_pio
  // Verify stops at a sector that keeps failing after retries
  task automatic t_vfy();
    t0 = tries;
    badSector <= 8'h0B;
    issue(8'h0A, 8'h00, CMD_VERIFY_NR);
    wait_irq();
    rd(OFF_COMMAND, 16'h0051, "err status");
    rd(OFF_FEATURE, 16'h0040, "uncorrectable");
    rd(OFF_TALLY, 16'h00FF, "left tally");
    rd(OFF_SECTOR, 16'h000B, "fail sector");
    chk("tries", 16'h0004, 16'(tries - t0));
    badSector <= 8'hFF;
    $display("verify error done");
  endtask : t_vfy
  // Multiple read without block size is aborted
  task automatic t_abort();
    issue(8'h01, 8'h01, CMD_READ_MULT);
    wait_irq();
    rd(OFF_COMMAND, 16'h0051, "abort status");
    rd(OFF_FEATURE, 16'h0004, "aborted");
    $display("abort done");
  endtask : t_abort
  // Block of two, then a one-sector block; flags only per block
  task automatic t_mult();
    issue(8'h10, 8'h02, CMD_SET_MULT);
    wait_irq();
    rd(OFF_COMMAND, 16'h0050, "setup status");
    issue(8'h10, 8'h03, CMD_READ_MULT);
    wait_irq();
    rd(OFF_COMMAND, 16'h0058, "block status");
    words(8'h10);
    repeat (3) @(posedge clk);
    chk("mid intrq", 16'h0000, {15'h0000, intrq});
    words(8'h11);
    wait_irq();
    rd(OFF_COMMAND, 16'h0058, "block status");
    words(8'h12);
    rd(OFF_TALLY, 16'h0000, "mult tally");
    rd(OFF_SECTOR, 16'h0012, "mult sector");
    $display("multiple read done");
  endtask : t_mult
  // Mode setup, then two sectors by DMA with one closing interrupt
  task automatic t_dma();
    wr(OFF_FEATURE, FEAT_XFER_MODE);
    issue(8'h20, 8'h42, CMD_SET_FEAT);
    wait_irq();
    rd(OFF_COMMAND, 16'h0050, "mode status");
    chk("mode", 16'h0042, {8'h00, xferMode});
    issue(8'h20, 8'h02, CMD_DMA);
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < 200 && dmarq !== 1'b1; i++) @(posedge clk);
      chk("dma intrq", 16'h0000, {15'h0000, intrq});
      @(posedge clk) dmaStrobe <= 1'b1;
      repeat (4) @(posedge clk);
      dmaStrobe <= 1'b0;
      #1 chk("dma word", {8'hD0, 8'(8'h20 + s)}, hostRdData);
    end
    wait_irq();
    rd(OFF_TALLY, 16'h0000, "dma tally");
    rd(OFF_SECTOR, 16'h0021, "dma sector");
    rd(OFF_COMMAND, 16'h0050, "dma status");
    $display("dma read done");
  endtask : t_dma
  task automatic conclude();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  // Main sequence
  initial begin
    {reset, hostWr, hostRd, dmaStrobe, hostAddr, hostWrData} =
      {1'b1, 21'h000000};
    {badSector, fails, comparisons, cycles} = {8'hFF, 96'h0};
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_pio(CMD_READ);
    t_pio(CMD_READ_NR);
    t_vfy();
    t_abort();
    t_mult();
    t_dma();
    conclude();
  end
endmodule : disk_read_command_executor_tb
